/* File: clk_ctrl.sv */
// oscillator and multiplying-loop clock control with axi4-lite registers
// How it works
// RULE_01 - read-only crystal valid flag in crystal modes
// RULE_02 - source bit picks internal or external reference
// RULE_03 - internal reference divided by its divide field
// RULE_04 - software settles external oscillator before selecting
// RULE_05 - reference divided by pre-divider value
// RULE_06 - divided reference multiplied by multiplier value
// RULE_07 - output equals reference times multiplier over divider
// RULE_08 - software sets filter bits to divided reference
// RULE_09 - software sets range bits to output range
// RULE_10 - lock flag set once loop is stable
// RULE_11 - software keeps frequencies in designed ranges
// RULE_12 - lock cleared when disabled or reconfigured
// RULE_13 - control register fields access and reset
`include "clk_ctrl_map.svh"
module clk_ctrl #(
   parameter int unsigned XTAL_SETTLE = `XTAL_SETTLE_CYC,
   parameter int unsigned LOCK_WAIT = `LOCK_CYC
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [5:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [5:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic xtal_running,
   output logic loop_enable,
   output logic loop_ref_source_bit,
   output logic [1:0] int_osc_divide_field,
   output logic [4:0] ref_predivider_value,
   output logic [7:0] loop_multiplier_value,
   output logic [3:0] loop_filter_field,
   output logic [1:0] osc_range_field,
   output logic [2:0] ext_osc_mode_field,
   output logic [2:0] ext_osc_drive_field,
   output logic [4:0] ref_div_total,
   output logic irq
);
   import clk_ctrl_pkg::*;

   reg8_t ext_osc_q, int_osc_q, loop_ctrl_q, prediv_q, mult_q, filt_q;
   logic [2:0] irq_stat_q, irq_mask_q, irq_stat_d;
   lock_state_t lock_q, lock_d;
   logic xtal_s1_q, xtal_s2_q;
   logic aw_got_q, w_got_q;
   logic [5:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic xtal_ok, lock_timer_done, crystal_valid_flag, loop_lock_flag;
   logic lock_prev_q, valid_prev_q;
   logic [4:0] div_total_d;

   // two flops since the oscillator status comes from analog
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         xtal_s1_q <= 1'b0;
         xtal_s2_q <= 1'b0;
      end else begin
         xtal_s1_q <= xtal_running;
         xtal_s2_q <= xtal_s1_q;
      end
   end

   wire crystal_mode = ext_osc_q[6:5] == 2'b11;
   wire xtal_run = crystal_mode && xtal_s2_q;
   settle_timer #(.COUNT(XTAL_SETTLE)) u_xtal_timer (
      .aclk(aclk), .aresetn(aresetn), .run(xtal_run), .restart(1'b0), .done(xtal_ok)
   );
   assign crystal_valid_flag = xtal_ok; // see RULE_01

   // write channel: address and data taken in either order
   wire wr_go = aw_got_q && w_got_q && !s_axi_bvalid;
   wire [3:0] wr_idx = aw_addr_q[5:2];
   wire [3:0] rd_idx = s_axi_araddr[5:2];
   wire wr_hit = wr_go && w_strb_q[0];
   wire wr_ext = wr_hit && wr_idx == `OFS_EXT_OSC_CTRL;
   wire wr_int = wr_hit && wr_idx == `OFS_INT_OSC_CTRL;
   wire wr_ctl = wr_hit && wr_idx == `OFS_LOOP_CTRL;
   wire wr_div = wr_hit && wr_idx == `OFS_LOOP_PREDIV;
   wire wr_mul = wr_hit && wr_idx == `OFS_LOOP_MULT;
   wire wr_flt = wr_hit && wr_idx == `OFS_LOOP_FILTER;
   wire wr_sts = wr_hit && wr_idx == `OFS_IRQ_STATUS;
   wire wr_msk = wr_hit && wr_idx == `OFS_IRQ_MASK;
   wire wr_bad = wr_idx > `OFS_IRQ_MASK;
   wire rd_bad = rd_idx > `OFS_IRQ_MASK;

   // any change of source, pre-divider, multiplier or enable, or of the internal divide while the internal source is selected, restarts lock
   wire [7:0] wd = w_data_q[7:0];
   wire cfg_change = (wr_ctl && (wd[`BIT_LOOP_SRC] != loop_ctrl_q[`BIT_LOOP_SRC]
                      || wd[`BIT_LOOP_ENABLE] != loop_ctrl_q[`BIT_LOOP_ENABLE]))
                     || (wr_div && wd != prediv_q) || (wr_mul && wd != mult_q)
                     || (wr_int && wd[1:0] != int_osc_q[1:0] && !loop_ctrl_q[`BIT_LOOP_SRC]);
   wire loop_on = loop_ctrl_q[`BIT_LOOP_ENABLE];
   settle_timer #(.COUNT(LOCK_WAIT)) u_lock_timer (
      .aclk(aclk), .aresetn(aresetn), .run(lock_q == lock_wait), .restart(cfg_change),
      .done(lock_timer_done)
   );

   always_comb begin
      lock_d = lock_q;
      unique case (lock_q)
         lock_off: if (loop_on) lock_d = lock_wait;
         lock_wait: if (lock_timer_done && !cfg_change) lock_d = lock_done; // see RULE_10
         lock_done: if (cfg_change) lock_d = lock_wait;
      endcase
      if (!loop_on) lock_d = lock_off; // see RULE_12
   end
   assign loop_lock_flag = lock_q == lock_done;

   // events: lock gained, lock lost, crystal became valid; set beats clear
   wire [2:0] evt = {crystal_valid_flag && !valid_prev_q, !loop_lock_flag && lock_prev_q,
                     loop_lock_flag && !lock_prev_q};
   assign irq_stat_d = (irq_stat_q & ~(wr_sts ? wd[2:0] : 3'h0)) | evt;

   // reference divide: internal source multiplies the predivider by 2^int_osc_divide_field
   wire [4:0] pre = (prediv_q[4:0] == 5'h0) ? 5'h1 : prediv_q[4:0];
   assign div_total_d = loop_ctrl_q[`BIT_LOOP_SRC] ? pre : 5'(pre << int_osc_q[1:0]); // see RULE_02 see RULE_03 see RULE_05

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ext_osc_q <= `RST_EXT_OSC;
         int_osc_q <= `RST_INT_OSC;
         loop_ctrl_q <= `RST_LOOP_CTRL;
         prediv_q <= `RST_PREDIV;
         mult_q <= `RST_MULT;
         filt_q <= `RST_FILTER;
         irq_stat_q <= 3'h0;
         irq_mask_q <= 3'h0;
         lock_q <= lock_off;
         lock_prev_q <= 1'b0;
         valid_prev_q <= 1'b0;
      end else begin
         if (wr_ext) ext_osc_q <= {1'b0, wd[6:4], 1'b0, wd[2:0]}; // see RULE_13
         if (wr_int) int_osc_q <= {6'h0, wd[1:0]};
         if (wr_ctl) loop_ctrl_q <= {5'h0, wd[`BIT_LOOP_SRC], 1'b0, wd[`BIT_LOOP_ENABLE]};
         if (wr_div) prediv_q <= {3'h0, wd[4:0]};
         if (wr_mul) mult_q <= wd; // see RULE_06 see RULE_07
         if (wr_flt) filt_q <= {2'h0, wd[5:0]};
         if (wr_msk) irq_mask_q <= wd[2:0];
         irq_stat_q <= irq_stat_d;
         lock_q <= lock_d;
         lock_prev_q <= loop_lock_flag;
         valid_prev_q <= crystal_valid_flag;
      end
   end

   // outputs registered one stage after the register file
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         loop_enable <= 1'b0;
         loop_ref_source_bit <= 1'b0;
         int_osc_divide_field <= 2'h0;
         ref_predivider_value <= 5'h0;
         loop_multiplier_value <= 8'h0;
         loop_filter_field <= 4'h0;
         osc_range_field <= 2'h0;
         ext_osc_mode_field <= 3'h0;
         ext_osc_drive_field <= 3'h0;
         ref_div_total <= 5'h1;
         irq <= 1'b0;
      end else begin
         loop_enable <= loop_on;
         loop_ref_source_bit <= loop_ctrl_q[`BIT_LOOP_SRC];
         int_osc_divide_field <= int_osc_q[1:0];
         ref_predivider_value <= prediv_q[4:0];
         loop_multiplier_value <= mult_q;
         loop_filter_field <= filt_q[3:0];
         osc_range_field <= filt_q[5:4];
         ext_osc_mode_field <= ext_osc_q[6:4];
         ext_osc_drive_field <= ext_osc_q[2:0];
         ref_div_total <= div_total_d;
         irq <= |(irq_stat_q & irq_mask_q);
      end
   end

   // read mux
   reg8_t rd_val;
   always_comb begin
      rd_val = 8'h00;
      unique case (rd_idx)
         `OFS_EXT_OSC_CTRL: rd_val = {crystal_valid_flag, ext_osc_q[6:4], 1'b0, ext_osc_q[2:0]};
         `OFS_INT_OSC_CTRL: rd_val = int_osc_q;
         `OFS_LOOP_CTRL: rd_val = {2'b00, loop_lock_flag, 2'b00, loop_ctrl_q[2:0]};
         `OFS_LOOP_PREDIV: rd_val = prediv_q;
         `OFS_LOOP_MULT: rd_val = mult_q;
         `OFS_LOOP_FILTER: rd_val = filt_q;
         `OFS_IRQ_STATUS: rd_val = {5'h0, irq_stat_q};
         `OFS_IRQ_MASK: rd_val = {5'h0, irq_mask_q};
         default: rd_val = 8'h00;
      endcase
   end

   // axi handshakes; one write and one read outstanding
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         aw_addr_q <= 6'h0;
         w_data_q <= 32'h0;
         w_strb_q <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= 2'b00;
      end else begin
         s_axi_awready <= !aw_got_q && !s_axi_awready && s_axi_awvalid;
         s_axi_wready <= !w_got_q && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_bad ? 2'b10 : 2'b00;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h0, rd_val};
            s_axi_rresp <= rd_bad ? 2'b10 : 2'b00;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule : clk_ctrl

/* File: clk_ctrl_map.svh */
// register offsets, field positions, reset values and timing counts
`ifndef CLK_CTRL_MAP_SVH
`define CLK_CTRL_MAP_SVH
`define OFS_EXT_OSC_CTRL 4'h0
`define OFS_INT_OSC_CTRL 4'h1
`define OFS_LOOP_CTRL 4'h2
`define OFS_LOOP_PREDIV 4'h3
`define OFS_LOOP_MULT 4'h4
`define OFS_LOOP_FILTER 4'h5
`define OFS_IRQ_STATUS 4'h6
`define OFS_IRQ_MASK 4'h7
`define BIT_XTAL_VALID 7
`define BIT_LOOP_ENABLE 0
`define BIT_LOOP_SRC 2
`define BIT_LOOP_LOCK 5
`define RST_EXT_OSC 8'h00
`define RST_INT_OSC 8'h00
`define RST_LOOP_CTRL 8'h00
`define RST_PREDIV 8'h01
`define RST_MULT 8'h01
`define RST_FILTER 8'h00
`define XTAL_SETTLE_US 1000
`define LOCK_TIME_US 50
`define CLK_MHZ 100
`define XTAL_SETTLE_CYC (`XTAL_SETTLE_US * `CLK_MHZ)
`define LOCK_CYC (`LOCK_TIME_US * `CLK_MHZ)
`endif

/* File: clk_ctrl_pkg.sv */
// types shared by the clock control block
package clk_ctrl_pkg;
   typedef enum logic [1:0] {lock_off, lock_wait, lock_done} lock_state_t;
   typedef logic [7:0] reg8_t;
endpackage : clk_ctrl_pkg

/* File: settle_timer.sv */
// restartable settle counter that raises done after a programmed count
module settle_timer #(
   parameter int unsigned COUNT = 16
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic run,
   input wire logic restart,
   output logic done
);
   logic [31:0] cnt_q;
   logic [31:0] cnt_d;
   logic done_d;
   assign cnt_d = (!run || restart) ? 32'h0 : (done ? cnt_q : cnt_q + 32'h1);
   assign done_d = run && !restart && (cnt_q >= COUNT - 1);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q <= 32'h0;
         done <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         done <= done_d;
      end
   end
endmodule : settle_timer

/* File: clk_ctrl_sva.sv */
// assertion checker for the clock control block
module clk_ctrl_sva #(
   parameter int unsigned XTAL_SETTLE = 8,
   parameter int unsigned LOCK_WAIT = 4
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [5:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic [5:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic loop_ref_source_bit,
   input wire logic [1:0] int_osc_divide_field,
   input wire logic [4:0] ref_predivider_value,
   input wire logic [7:0] loop_multiplier_value,
   input wire logic [2:0] ext_osc_mode_field,
   input wire logic [2:0] ext_osc_drive_field,
   input wire logic [4:0] ref_div_total
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [3:0] wa_q;
   logic [7:0] wd_q;
   logic ws_q;
   // zero pre-divide runs as one
   wire logic [4:0] pd_eff = (ref_predivider_value == 5'h00) ? 5'h01 : ref_predivider_value;
   always_ff @(posedge aclk) begin
      if (s_axi_awvalid && s_axi_awready) wa_q <= s_axi_awaddr[5:2];
      if (s_axi_wvalid && s_axi_wready) begin
         wd_q <= s_axi_wdata[7:0];
         ws_q <= s_axi_wstrb[0];
      end
   end
   sequence cfg_still;
      $stable(ref_predivider_value) && $stable(loop_ref_source_bit) && $stable(int_osc_divide_field);
   endsequence
   sequence wr_done(logic [3:0] idx);
      $rose(s_axi_bvalid) && wa_q == idx && ws_q;
   endsequence
   AST_SRC_EXT: assert property (cfg_still ##1 cfg_still ##0 loop_ref_source_bit |-> ref_div_total == pd_eff)
      else $error("external reference divide wrong");
   AST_SRC_INT: assert property (cfg_still ##1 cfg_still ##0 !loop_ref_source_bit |->
      ref_div_total == 5'(pd_eff << int_osc_divide_field)) else $error("internal reference divide wrong");
   AST_EXT_FIELDS: assert property (wr_done(4'h0) |-> ##[0:2]
      (ext_osc_mode_field == wd_q[6:4] && ext_osc_drive_field == wd_q[2:0])) else $error("osc fields not updated");
   AST_PREDIV: assert property (wr_done(4'h3) |-> ##[0:2] ref_predivider_value == wd_q[4:0])
      else $error("pre-divider not updated");
   AST_MULT: assert property (wr_done(4'h4) |-> ##[0:2] loop_multiplier_value == wd_q)
      else $error("multiplier not updated");
   AST_NO_AR_IN_R: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("address taken during read data");
   AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
      else $error("read not answered");
   AST_SLVERR: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[5:2] > 4'h7 |->
      ##[1:2] (s_axi_rvalid && s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)) else $error("unmapped read wrong");
endmodule : clk_ctrl_sva
bind clk_ctrl clk_ctrl_sva #(.XTAL_SETTLE(XTAL_SETTLE), .LOCK_WAIT(LOCK_WAIT)) sva_i (.aclk, .aresetn, .s_axi_awaddr,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
   .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .loop_ref_source_bit,
   .int_osc_divide_field, .ref_predivider_value, .loop_multiplier_value, .ext_osc_mode_field, .ext_osc_drive_field,
   .ref_div_total);

/* File: clk_ctrl_tb_top.sv */
// self-checking bench for the clock control block
`include "clk_ctrl_map.svh"
module clk_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk, aresetn, xtal_running, irq, loop_enable, loop_ref_source_bit;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [5:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd_v;
   logic [3:0] s_axi_wstrb, loop_filter_field;
   logic [1:0] s_axi_bresp, s_axi_rresp, int_osc_divide_field, osc_range_field, resp;
   logic [4:0] ref_predivider_value, ref_div_total;
   logic [7:0] loop_multiplier_value;
   logic [2:0] ext_osc_mode_field, ext_osc_drive_field;
   logic [3:0] rst_a [4] = '{`OFS_EXT_OSC_CTRL, `OFS_LOOP_PREDIV, `OFS_LOOP_MULT, `OFS_IRQ_MASK};
   logic [7:0] rst_v [4] = '{8'h00, 8'h01, 8'h01, 8'h00};
   int failures = 0;
   int cmp_count = 0;
   // short settle and lock counts keep the run brief
   clk_ctrl #(.XTAL_SETTLE(30), .LOCK_WAIT(40)) uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .xtal_running, .loop_enable, .loop_ref_source_bit, .int_osc_divide_field, .ref_predivider_value,
      .loop_multiplier_value, .loop_filter_field, .osc_range_field, .ext_osc_mode_field, .ext_osc_drive_field,
      .ref_div_total, .irq);
   function automatic logic [5:0] ba(input logic [3:0] i);
      return {i, 2'b00};
   endfunction : ba
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // one edge first so a ready from the last call never drops in the same step
   task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic st = 1'b1);
      logic b;
      b = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_wstrb <= {3'h0, st};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      // no cycle budget here: only the watchdog ends a wait
      while (!b) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         b = s_axi_bvalid;
         resp = s_axi_bresp;
      end
      s_axi_bready <= 1'b0;
      chk(b, 1'b1);
   endtask : wr
   task automatic rd(input logic [5:0] a, output logic [31:0] d);
      logic b;
      b = 1'b0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!b) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         b = s_axi_rvalid;
         d = s_axi_rdata;
         resp = s_axi_rresp;
      end
      s_axi_rready <= 1'b0;
      chk(b, 1'b1);
   endtask : rd
   task automatic rc(input logic [5:0] a, input logic [31:0] exp);
      rd(a, rd_v);
      chk({resp, rd_v}, {2'b00, exp});
   endtask : rc
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : wrap_up
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   initial begin
      #50us;
      failures++;
      wrap_up();
   end
   initial begin
      {aresetn, xtal_running, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      foreach (rst_a[i]) rc(ba(rst_a[i]), {24'h0, rst_v[i]});
      chk(ref_div_total, 5'h01);
      $display("test reset values done");
      wr(ba(`OFS_EXT_OSC_CTRL), 8'hff);
      rc(ba(`OFS_EXT_OSC_CTRL), 32'h77);
      xtal_running <= 1'b1;
      wr(ba(`OFS_EXT_OSC_CTRL), 8'h65);
      rc(ba(`OFS_EXT_OSC_CTRL), 32'h65);
      repeat (45) @(posedge aclk);
      rc(ba(`OFS_EXT_OSC_CTRL), 32'he5);
      wr(ba(`OFS_EXT_OSC_CTRL), 8'h45);
      repeat (3) @(posedge aclk);
      rc(ba(`OFS_EXT_OSC_CTRL), 32'h45);
      chk({ext_osc_mode_field, ext_osc_drive_field}, {3'h4, 3'h5});
      rc(ba(`OFS_IRQ_STATUS), 32'h04);
      // crystal settled again before it may serve as loop reference
      wr(ba(`OFS_EXT_OSC_CTRL), 8'h65);
      repeat (40) @(posedge aclk);
      rc(ba(`OFS_EXT_OSC_CTRL), 32'he5);
      $display("test oscillator control done");
      wr(ba(`OFS_IRQ_STATUS), 8'h07);
      wr(ba(`OFS_IRQ_MASK), 8'h01);
      wr(ba(`OFS_LOOP_PREDIV), 8'h03);
      wr(ba(`OFS_INT_OSC_CTRL), 8'h02);
      wr(ba(`OFS_LOOP_MULT), 8'h20);
      wr(ba(`OFS_LOOP_FILTER), 8'h35);
      repeat (2) @(posedge aclk);
      chk(ref_div_total, 5'h0c);
      chk(int_osc_divide_field, 2'h2);
      chk({loop_multiplier_value, osc_range_field, loop_filter_field}, {8'h20, 2'h3, 4'h5});
      wr(ba(`OFS_LOOP_CTRL), 8'h05);
      repeat (2) @(posedge aclk);
      chk({loop_enable, loop_ref_source_bit, ref_div_total}, {2'b11, 5'h03});
      $display("test reference path done");
      rc(ba(`OFS_LOOP_CTRL), 32'h05);
      chk(irq, 1'b0);
      repeat (45) @(posedge aclk);
      rc(ba(`OFS_LOOP_CTRL), 32'h25);
      rc(ba(`OFS_IRQ_STATUS), 32'h01);
      chk(irq, 1'b1);
      wr(ba(`OFS_IRQ_MASK), 8'h00);
      repeat (2) @(posedge aclk);
      chk(irq, 1'b0);
      wr(ba(`OFS_IRQ_MASK), 8'h03);
      wr(ba(`OFS_LOOP_MULT), 8'h21);
      rc(ba(`OFS_LOOP_CTRL), 32'h05);
      rc(ba(`OFS_IRQ_STATUS), 32'h03);
      chk(irq, 1'b1);
      wr(ba(`OFS_IRQ_STATUS), 8'h03);
      repeat (2) @(posedge aclk);
      chk(irq, 1'b0);
      wr(ba(`OFS_LOOP_CTRL), 8'h04);
      repeat (50) @(posedge aclk);
      rc(ba(`OFS_LOOP_CTRL), 32'h04);
      $display("test lock and interrupt done");
      wr(6'h20, 8'h11);
      chk(resp, 2'b10);
      rd(6'h3c, rd_v);
      chk({resp, rd_v}, {2'b10, 32'h0});
      wr(ba(`OFS_LOOP_MULT), 8'h99, 1'b0);
      rc(ba(`OFS_LOOP_MULT), 32'h21);
      $display("test unmapped access done");
      wrap_up();
   end
endmodule : clk_ctrl_tb_top
